//--- logic/sas_pkg.sv
// constants, mode codes and state types of the successive-approximation sequencer
`default_nettype none

package sas_pkg;

   // ------------------------------------------------------------
   // converter geometry
   // ------------------------------------------------------------
   localparam int unsigned SAS_RES_W = 10;
   localparam int unsigned SAS_NCH   = 8;
   localparam int unsigned SAS_CH_W  = 3;
   localparam int unsigned SAS_DIV_W = 3;

   // ------------------------------------------------------------
   // operating modes and start sources
   // ------------------------------------------------------------
   localparam logic [2:0] SAS_MODE_FIXED_SINGLE = 3'h0;
   localparam logic [2:0] SAS_MODE_FIXED_CONT   = 3'h1;
   localparam logic [2:0] SAS_MODE_SCAN_SINGLE  = 3'h2;
   localparam logic [2:0] SAS_MODE_SCAN_CONT    = 3'h3;
   localparam logic [2:0] SAS_MODE_DUAL_CONT    = 3'h4;
   localparam logic [2:0] SAS_MODE_SINGLE_STEP  = 3'h5;

   localparam logic [1:0] SAS_SRC_TIMER = 2'h0;
   localparam logic [1:0] SAS_SRC_IMM   = 2'h1;
   localparam logic [1:0] SAS_SRC_EDGE  = 2'h2;

   // ------------------------------------------------------------
   // bit positions, group sizes and clock range
   // ------------------------------------------------------------
   localparam logic [3:0] SAS_MSB_BIT     = 4'h9;
   localparam logic [3:0] SAS_EARLY4_BIT  = 4'h6;  // last bit of the four MSBs
   localparam logic [3:0] SAS_EARLY8_BIT  = 4'h2;  // last bit of the eight MSBs
   localparam logic [3:0] SAS_SCAN_SPLIT  = 4'h4;  // split point of a scan
   localparam logic [3:0] SAS_CH_NONE     = 4'h8;  // no further channel
   localparam logic [2:0] SAS_GROUP4_MASK = 3'h3;
   localparam logic [2:0] SAS_GROUP8_MASK = 3'h7;
   localparam int unsigned SAS_SYS_CLK_KHZ    = 100000;
   localparam int unsigned SAS_ADC_CLK_MIN_KHZ = 500;
   localparam int unsigned SAS_ADC_CLK_MAX_KHZ = 3000;

   // ------------------------------------------------------------
   // sequencer state and full register image
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      SAS_ST_IDLE   = 4'b0001,
      SAS_ST_SAMPLE = 4'b0010,
      SAS_ST_CONV   = 4'b0100,
      SAS_ST_STORE  = 4'b1000
   } sas_state_t;

   typedef struct packed {
      sas_state_t                     st;
      logic [SAS_DIV_W-1:0]           div_cnt;
      logic [3:0]                     bit_idx;
      logic [SAS_RES_W-1:0]           sar;
      logic [SAS_RES_W-1:0]           dac;
      logic [SAS_CH_W-1:0]            cur_ch;
      logic                           sh;
      logic [2:0]                     wr_idx;
      logic [2:0]                     grp_cnt;
      logic [3:0]                     scan_cnt;
      logic [3:0]                     step_ptr;
      logic                           dual_sel;
      logic                           trig_prev;
      logic                           bnd_hit;
      logic                           done_flag;
      logic                           bnd_flag;
      logic [SAS_NCH-1:0]             bnd_status;
      logic [SAS_NCH-1:0][SAS_RES_W-1:0] results;
   } sas_regs_t;

endpackage

`default_nettype wire

//--- logic/sas_sequencer.sv
// successive-approximation converter sequencer with modes, start sources and limits
// What this block does
// - resolve ten bits per sample via SAR, DAC and comparator over eight inputs
// - fixed single: convert chosen input once, store in its pair, flag completion
// - fixed continuous: results fill the eight pairs in turn, wrapping around
// - fixed continuous: interrupt every four or every eight conversions
// - continuous modes run on without new starts until software stops them
// - scan single: convert each selected input once into its own pair
// - scan: interrupt after all channels, or after four and after the rest
// - scan continuous: restart at first selected channel, results cycle eight pairs
// - dual: alternate two inputs, results into pairs 0,1,2,3 onward
// - dual: interrupt after each group of four or eight conversions
// - single step: convert next scan channel, flag, then wait for next start
// - timer overflow starts a conversion; overflows while busy are ignored
// - immediate source: writing the start setting starts at once
// - either edge of trigger pin starts; edges while busy are ignored
// - compare result against high and low limits, inside or outside selectable
// - clearing the limit interrupt enable stops limit interrupts entirely
// - outside criterion: early compare of four MSBs against both limits
// - no early hit: compare again once eight MSBs are resolved
// - set per-channel flag for each channel that caused a limit interrupt
// - clock divider by one to eight; software keeps rate within range
// - keeps working in idle and completion may wake the device
// - power-down halts the converter; disabling it saves power
`timescale 1ns/10ps
`default_nettype none

module sas_sequencer
   import sas_pkg::*;
(
   input  wire logic                               clk,
   input  wire logic                               rst_n,
   input  wire logic                               enable,
   input  wire logic                               power_down,
   input  wire logic [2:0]                         mode,
   input  wire logic [1:0]                         start_src,
   input  wire logic                               start_write,
   input  wire logic                               timer0_overflow,
   input  wire logic                               external_trigger_pin,
   input  wire logic [sas_pkg::SAS_CH_W-1:0]       chan_sel,
   input  wire logic [sas_pkg::SAS_NCH-1:0]        chan_set,
   input  wire logic [sas_pkg::SAS_CH_W-1:0]       dual_ch_a,
   input  wire logic [sas_pkg::SAS_CH_W-1:0]       dual_ch_b,
   input  wire logic                               irq_group8,
   input  wire logic                               scan_irq_after4,
   input  wire logic [sas_pkg::SAS_DIV_W-1:0]      clk_div,
   input  wire logic [sas_pkg::SAS_RES_W-1:0]      bound_high,
   input  wire logic [sas_pkg::SAS_RES_W-1:0]      bound_low,
   input  wire logic                               bound_inside_sel,
   input  wire logic                               bound_irq_en,
   input  wire logic                               conv_irq_en,
   input  wire logic                               done_clear,
   input  wire logic                               bound_clear,
   input  wire logic                               comp_high,
   output logic [sas_pkg::SAS_CH_W-1:0]            mux_sel,
   output logic                                    sample_hold,
   output logic [sas_pkg::SAS_RES_W-1:0]           dac_code,
   output logic [sas_pkg::SAS_NCH-1:0][sas_pkg::SAS_RES_W-1:0] result_pairs,
   output logic                                    conv_done_flag,
   output logic                                    boundary_flag,
   output logic [sas_pkg::SAS_NCH-1:0]             boundary_status,
   output logic                                    conv_irq,
   output logic                                    bound_irq,
   output logic                                    wake_request,
   output logic                                    busy
);

   import sas_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------

   // lowest selected channel at or above from; SAS_CH_NONE when none
   function automatic logic [3:0] find_from(input logic [SAS_NCH-1:0] mask,
                                            input logic [3:0]         from);
      logic [3:0] res;
      res = SAS_CH_NONE;
      for (int i = SAS_NCH - 1; i >= 0; i--) begin
         if (mask[i] && (4'(i) >= from)) begin
            res = 4'(i);
         end
      end
      return res;
   endfunction

   // ------------------------------------------------------------
   // state and derived terms
   // ------------------------------------------------------------
   sas_regs_t r_reg;
   sas_regs_t r_next;

   logic       running;
   logic       tick;
   logic       edge_seen;
   logic       start_req;
   logic [3:0] first_ch;
   logic [3:0] next_ch;
   logic [3:0] step_ch;
   logic       conv_evt;
   logic       bnd_evt;
   logic       is_cont;
   logic       group_hit;
   logic [SAS_RES_W-1:0] sar_new;
   logic       final_inside;

   // power-down or disable sends the sequencer to idle and holds the divider at zero
   // halt when powered down
   assign running = enable & ~power_down;

   // divider: count 0..clk_div gives division by clk_div+1
   // divide by one to eight
   assign tick = running & (r_reg.div_cnt == clk_div);

   assign edge_seen = external_trigger_pin ^ r_reg.trig_prev;

   assign start_req = ((start_src == SAS_SRC_TIMER) & timer0_overflow)
                    | ((start_src == SAS_SRC_IMM) & start_write)
                    | ((start_src == SAS_SRC_EDGE) & edge_seen);

   assign first_ch = find_from(chan_set, 4'h0);
   assign next_ch  = find_from(chan_set, {1'b0, r_reg.cur_ch} + 4'h1);
   assign step_ch  = (find_from(chan_set, r_reg.step_ptr) == SAS_CH_NONE) ?
                     first_ch : find_from(chan_set, r_reg.step_ptr);

   assign is_cont = (mode == SAS_MODE_FIXED_CONT) | (mode == SAS_MODE_SCAN_CONT)
                  | (mode == SAS_MODE_DUAL_CONT);

   assign group_hit = irq_group8 ? (r_reg.grp_cnt == SAS_GROUP8_MASK) :
                      ((r_reg.grp_cnt & SAS_GROUP4_MASK) == SAS_GROUP4_MASK);

   // keep trial bit when held input is at or above the dac level
   assign sar_new = comp_high ? r_reg.dac : r_reg.sar;

   assign final_inside = (r_reg.sar <= bound_high) & (r_reg.sar >= bound_low);

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      r_next   = r_reg;
      conv_evt = 1'b0;
      bnd_evt  = 1'b0;
      r_next.trig_prev = external_trigger_pin;

      // divider only runs while the converter is powered
      if (!running || tick) begin
         r_next.div_cnt = '0;
      end else begin
         r_next.div_cnt = r_reg.div_cnt + 3'h1;
      end

      unique case (r_reg.st)
         SAS_ST_IDLE: begin
            // starts only taken when idle, so busy triggers are dropped
            if (running && start_req) begin
               r_next.st       = SAS_ST_SAMPLE;
               r_next.wr_idx   = '0;
               r_next.grp_cnt  = '0;
               r_next.scan_cnt = '0;
               r_next.dual_sel = 1'b0;
               unique case (mode)
                  SAS_MODE_SCAN_SINGLE, SAS_MODE_SCAN_CONT: begin
                     r_next.cur_ch = first_ch[2:0];
                     if (first_ch == SAS_CH_NONE) begin
                        r_next.st = SAS_ST_IDLE;
                     end
                  end
                  SAS_MODE_DUAL_CONT: begin
                     r_next.cur_ch = dual_ch_a;
                  end
                  SAS_MODE_SINGLE_STEP: begin
                     r_next.cur_ch = step_ch[2:0];
                     if (step_ch == SAS_CH_NONE) begin
                        r_next.st = SAS_ST_IDLE;
                     end
                  end
                  default: begin
                     r_next.cur_ch = chan_sel;
                  end
               endcase
            end
         end
         SAS_ST_SAMPLE: begin
            // sample until the next tick, then start at the MSB
            r_next.bnd_hit = 1'b0;
            if (tick) begin
               r_next.st      = SAS_ST_CONV;
               r_next.bit_idx = SAS_MSB_BIT;
               r_next.sar     = '0;
               r_next.dac     = 10'h0200;
            end
         end
         SAS_ST_CONV: begin
            if (tick) begin
               r_next.sar = sar_new;
               if (!bound_inside_sel && (r_reg.bit_idx == SAS_EARLY4_BIT) &&
                   ((sar_new[9:6] > bound_high[9:6]) || (sar_new[9:6] < bound_low[9:6]))) begin
                  bnd_evt = 1'b1;
               end
               if (!bound_inside_sel && !r_reg.bnd_hit &&
                   (r_reg.bit_idx == SAS_EARLY8_BIT) &&
                   ((sar_new[9:2] > bound_high[9:2]) || (sar_new[9:2] < bound_low[9:2]))) begin
                  bnd_evt = 1'b1;
               end
               if (r_reg.bit_idx == 4'h0) begin
                  r_next.st  = SAS_ST_STORE;
                  r_next.dac = sar_new;
               end else begin
                  r_next.bit_idx = r_reg.bit_idx - 4'h1;
                  r_next.dac     = sar_new | 10'(10'h0001 << (r_reg.bit_idx - 4'h1));
               end
            end
         end
         SAS_ST_STORE: begin
            // full-width compare unless an early compare already hit
            if (!r_reg.bnd_hit && (bound_inside_sel ? final_inside : !final_inside)) begin
               bnd_evt = 1'b1;
            end
            r_next.grp_cnt = r_reg.grp_cnt + 3'h1;
            r_next.st      = SAS_ST_SAMPLE;
            // continuous modes walk the pairs and wrap
            if (is_cont) begin
               r_next.results[r_reg.wr_idx] = r_reg.sar;
               r_next.wr_idx = r_reg.wr_idx + 3'h1;
            end else begin
               r_next.results[r_reg.cur_ch] = r_reg.sar;
            end
            unique case (mode)
               SAS_MODE_FIXED_SINGLE: begin
                  conv_evt  = 1'b1;
                  r_next.st = SAS_ST_IDLE;
               end
               SAS_MODE_FIXED_CONT: begin
                  conv_evt = group_hit;
               end
               SAS_MODE_DUAL_CONT: begin
                  conv_evt        = group_hit;
                  r_next.dual_sel = ~r_reg.dual_sel;
                  r_next.cur_ch   = r_reg.dual_sel ? dual_ch_a : dual_ch_b;
               end
               SAS_MODE_SCAN_SINGLE, SAS_MODE_SCAN_CONT: begin
                  r_next.scan_cnt = r_reg.scan_cnt + 4'h1;
                  conv_evt = (next_ch == SAS_CH_NONE) |
                             (scan_irq_after4 & ((r_reg.scan_cnt + 4'h1) == SAS_SCAN_SPLIT));
                  if (next_ch != SAS_CH_NONE) begin
                     r_next.cur_ch = next_ch[2:0];
                  end else if (mode == SAS_MODE_SCAN_SINGLE) begin
                     r_next.st = SAS_ST_IDLE;
                  end else begin
                     // restart at the first selected channel
                     r_next.cur_ch   = first_ch[2:0];
                     r_next.scan_cnt = '0;
                  end
               end
               SAS_MODE_SINGLE_STEP: begin
                  conv_evt        = 1'b1;
                  r_next.st       = SAS_ST_IDLE;
                  r_next.step_ptr = {1'b0, r_reg.cur_ch} + 4'h1;
               end
               default: begin
                  // unknown mode code behaves as one-shot
                  conv_evt  = 1'b1;
                  r_next.st = SAS_ST_IDLE;
               end
            endcase
         end
         default: begin
            r_next.st = SAS_ST_IDLE;
         end
      endcase

      // continuous runs end only when software disables or powers down the converter
      if (!running) begin
         r_next.st = SAS_ST_IDLE;
      end

      // hold tracks every sampling cycle, restarts included
      r_next.sh = (r_next.st == SAS_ST_SAMPLE);

      // remember an early hit so one conversion raises at most one limit event
      if (bnd_evt) begin
         r_next.bnd_hit = 1'b1;
      end

      // completion flag, set wins over clear
      r_next.done_flag = conv_evt | (r_reg.done_flag & ~done_clear);

      // limit events only while their enable is set
      // per-channel limit flags, set wins over clear
      r_next.bnd_flag   = (bnd_evt & bound_irq_en) | (r_reg.bnd_flag & ~bound_clear);
      r_next.bnd_status = r_reg.bnd_status & ~{SAS_NCH{bound_clear}};
      if (bnd_evt && bound_irq_en) begin
         r_next.bnd_status[r_reg.cur_ch] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg    <= '0;
         r_reg.st <= SAS_ST_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign mux_sel         = r_reg.cur_ch;
   assign sample_hold     = r_reg.sh;
   assign dac_code        = r_reg.dac;
   assign result_pairs    = r_reg.results;
   assign conv_done_flag  = r_reg.done_flag;
   assign boundary_flag   = r_reg.bnd_flag;
   assign boundary_status = r_reg.bnd_status;
   assign conv_irq        = r_reg.done_flag & conv_irq_en;
   assign bound_irq       = r_reg.bnd_flag & bound_irq_en;
   // completion wakes from idle when its interrupt is enabled
   assign wake_request    = r_reg.done_flag & conv_irq_en;
   assign busy            = (r_reg.st != SAS_ST_IDLE);

endmodule

`default_nettype wire

//--- bench/sas_analog_model.sv
// behavioural front end: input multiplexer, sample-and-hold and comparator
`timescale 1ns/10ps
`default_nettype none
module sas_analog_model
   import sas_pkg::*;
(
   input  wire logic                                             clk,
   input  wire logic [sas_pkg::SAS_NCH-1:0][sas_pkg::SAS_RES_W-1:0] level,
   input  wire logic [sas_pkg::SAS_CH_W-1:0]                     mux_sel,
   input  wire logic                                             sample_hold,
   input  wire logic [sas_pkg::SAS_RES_W-1:0]                    dac_code,
   output logic                                                  comp_high
);
   logic [SAS_RES_W-1:0] held = '0;
   // hold the chosen input
   // tracks the input while sampling, frozen once the trial codes start
   always @(posedge clk) begin
      if (sample_hold) begin
         held <= level[mux_sel];
      end
   end
   assign comp_high = (held >= dac_code);
endmodule
`default_nettype wire

//--- bench/sas_sequencer_chk.sv
// port-level assertions for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module sas_sequencer_chk
   import sas_pkg::*;
(
   input wire logic                              clk,
   input wire logic                              rst_n,
   input wire logic                              enable,
   input wire logic                              power_down,
   input wire logic [2:0]                        mode,
   input wire logic [1:0]                        start_src,
   input wire logic                              start_write,
   input wire logic                              conv_irq_en,
   input wire logic                              bound_irq_en,
   input wire logic                              done_clear,
   input wire logic                              bound_clear,
   input wire logic                              sample_hold,
   input wire logic [sas_pkg::SAS_RES_W-1:0]     dac_code,
   input wire logic                              conv_done_flag,
   input wire logic                              boundary_flag,
   input wire logic [sas_pkg::SAS_NCH-1:0]       boundary_status,
   input wire logic                              conv_irq,
   input wire logic                              bound_irq,
   input wire logic                              wake_request,
   input wire logic                              busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // immediate start of a one-shot conversion while idle
   sequence s_start;
      !busy && enable && !power_down && start_src == SAS_SRC_IMM && start_write
         && mode == SAS_MODE_FIXED_SINGLE;
   endsequence
   sequence s_sample;
      busy && sample_hold;
   endsequence
   a_start_taken: assert property (s_start |=> s_sample)
      else $error("immediate start not taken");
   a_first_trial: assert property (s_sample ##1 (busy && !sample_hold) |-> dac_code == 10'h200)
      else $error("first trial code wrong");
   // sampling ends within one divided tick
   a_sample_len: assert property ($rose(sample_hold) |-> ##[1:8] !sample_hold)
      else $error("sampling too long");
   a_stop_off: assert property (!enable || power_down |=> !busy)
      else $error("converter ran while off");
   a_done_sticky: assert property (conv_done_flag && !done_clear |=> conv_done_flag)
      else $error("done flag lost");
   a_status_keep: assert property (!bound_clear |=>
      (boundary_status & $past(boundary_status)) == $past(boundary_status))
      else $error("boundary status bit lost");
   a_flag_chan: assert property (boundary_flag |-> boundary_status != '0)
      else $error("boundary flag without channel");
   a_irq_gate: assert property (conv_irq == (conv_done_flag && conv_irq_en))
      else $error("conversion interrupt wrong");
   a_bound_gate: assert property (bound_irq == (boundary_flag && bound_irq_en))
      else $error("boundary interrupt wrong");
   a_wake_irq: assert property (wake_request == conv_irq)
      else $error("wake request wrong");
endmodule
bind sas_sequencer sas_sequencer_chk u_sas_sequencer_chk (.clk, .rst_n, .enable, .power_down,
   .mode, .start_src, .start_write, .conv_irq_en, .bound_irq_en, .done_clear, .bound_clear,
   .sample_hold, .dac_code, .conv_done_flag, .boundary_flag, .boundary_status, .conv_irq,
   .bound_irq, .wake_request, .busy);
`default_nettype wire

//--- bench/tb_sas_sequencer.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_sas_sequencer;
   import sas_pkg::*;
   logic                              clk = 1'b0;
   logic                              rst_n = 1'b0;
   logic                              enable, power_down, start_write, timer0_overflow;
   logic                              external_trigger_pin, irq_group8, scan_irq_after4;
   logic                              bound_inside_sel, bound_irq_en, conv_irq_en;
   logic                              done_clear, bound_clear, comp_high, sample_hold;
   logic                              conv_done_flag, boundary_flag, conv_irq, bound_irq;
   logic                              wake_request, busy;
   logic [2:0]                        mode;
   logic [1:0]                        start_src;
   logic [SAS_CH_W-1:0]               chan_sel, dual_ch_a, dual_ch_b, mux_sel;
   logic [SAS_NCH-1:0]                chan_set, boundary_status;
   logic [SAS_DIV_W-1:0]              clk_div;
   logic [SAS_RES_W-1:0]              bound_high, bound_low, dac_code;
   logic [SAS_NCH-1:0][SAS_RES_W-1:0] result_pairs, ana;
   int                                n_errors = 0;
   int                                compares = 0;

   always #5 clk = ~clk;

   sas_sequencer u_sas_sequencer (.clk, .rst_n, .enable, .power_down, .mode, .start_src,
      .start_write, .timer0_overflow, .external_trigger_pin, .chan_sel, .chan_set, .dual_ch_a,
      .dual_ch_b, .irq_group8, .scan_irq_after4, .clk_div, .bound_high, .bound_low,
      .bound_inside_sel, .bound_irq_en, .conv_irq_en, .done_clear, .bound_clear, .comp_high,
      .mux_sel, .sample_hold, .dac_code, .result_pairs, .conv_done_flag, .boundary_flag,
      .boundary_status, .conv_irq, .bound_irq, .wake_request, .busy);
   sas_analog_model u_sas_analog_model (.clk, .level(ana), .mux_sel, .sample_hold, .dac_code,
      .comp_high);

   // ----------------------------------------
   // shared helpers
   // ----------------------------------------
   task automatic report_and_stop();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input logic [SAS_RES_W-1:0] seen, input logic [SAS_RES_W-1:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // wait for done flag or idle; a hang ends the run
   task automatic wait_on(input bit want_done);
      int k;
      k = 0;
      while ((want_done ? conv_done_flag !== 1'b1 : busy !== 1'b0) && k < 3000) begin
         @(negedge clk);
         k++;
      end
      if (k == 3000) begin
         n_errors++;
         report_and_stop();
      end
   endtask
   task automatic clr();
      done_clear = 1'b1;
      bound_clear = 1'b1;
      @(negedge clk);
      done_clear = 1'b0;
      bound_clear = 1'b0;
   endtask
   task automatic kick();
      start_write = 1'b1;
      @(negedge clk);
      start_write = 1'b0;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_single();
      for (int c = 0; c < 8; c++) begin
         mode = SAS_MODE_FIXED_SINGLE;
         chan_sel = c[2:0];
         clr();
         kick();
         wait_on(1'b0);
         check(result_pairs[c], ana[c]);
         check({9'h000, conv_irq}, 10'h001);
      end
   endtask
   task automatic t_cont();
      mode = SAS_MODE_FIXED_CONT;
      chan_sel = 3'h3;
      clk_div = 3'h1;
      clr();
      kick();
      wait_on(1'b1);
      for (int p = 0; p < 4; p++) check(result_pairs[p], ana[3]);
      check(result_pairs[4], ana[4]);
      repeat (260) @(negedge clk);
      check(result_pairs[7], ana[3]);
      check({9'h000, busy}, 10'h001);
      enable = 1'b0;
      @(negedge clk);
      check({9'h000, busy}, 10'h000);
      enable = 1'b1;
   endtask
   task automatic t_dual();
      mode = SAS_MODE_DUAL_CONT;
      irq_group8 = 1'b1;
      clr();
      kick();
      wait_on(1'b1);
      for (int p = 0; p < 8; p++) check(result_pairs[p], p[0] ? ana[6] : ana[1]);
      power_down = 1'b1;
      @(negedge clk);
      check({9'h000, busy}, 10'h000);
      power_down = 1'b0;
   endtask
   task automatic t_scan();
      mode = SAS_MODE_SCAN_SINGLE;
      chan_set = 8'hB5;
      scan_irq_after4 = 1'b1;
      clr();
      kick();
      wait_on(1'b1);
      check({9'h000, busy}, 10'h001);
      clr();
      wait_on(1'b0);
      check({9'h000, conv_done_flag}, 10'h001);
      for (int p = 0; p < 8; p++) check(result_pairs[p], chan_set[p] ? ana[p] : ana[p[0] ? 6 : 1]);
      mode = SAS_MODE_SINGLE_STEP;
      kick();
      wait_on(1'b0);
      kick();
      wait_on(1'b0);
      check({7'h00, mux_sel}, 10'h002);
   endtask
   task automatic t_starts();
      mode = SAS_MODE_FIXED_SINGLE;
      start_src = SAS_SRC_TIMER;
      timer0_overflow = 1'b1;
      @(negedge clk);
      timer0_overflow = 1'b0;
      @(negedge clk);
      timer0_overflow = 1'b1;
      check({9'h000, busy}, 10'h001);
      @(negedge clk);
      timer0_overflow = 1'b0;
      wait_on(1'b0);
      repeat (3) @(negedge clk);
      check({9'h000, busy}, 10'h000);
      start_src = SAS_SRC_EDGE;
      external_trigger_pin = 1'b1;
      @(negedge clk);
      check({9'h000, busy}, 10'h001);
      wait_on(1'b0);
      external_trigger_pin = 1'b0;
      @(negedge clk);
      check({9'h000, busy}, 10'h001);
      external_trigger_pin = 1'b1;
      wait_on(1'b0);
      repeat (3) @(negedge clk);
      check({9'h000, busy}, 10'h000);
      start_src = SAS_SRC_IMM;
   endtask
   task automatic t_bound();
      chan_sel = 3'h2;
      clk_div = 3'h0;
      ana[2] = 10'h3F0;
      clr();
      kick();
      repeat (7) @(negedge clk);
      check({8'h00, boundary_flag, busy}, 10'h003);
      wait_on(1'b0);
      check({2'h0, boundary_status}, 10'h004);
      check({9'h000, bound_irq}, 10'h001);
      ana[2] = 10'h2FF;
      bound_inside_sel = 1'b1;
      clr();
      kick();
      wait_on(1'b0);
      check({2'h0, boundary_status}, 10'h004);
      bound_irq_en = 1'b0;
      clr();
      kick();
      wait_on(1'b0);
      check({2'h0, boundary_status}, 10'h000);
   endtask

   // reset, then each scenario
   initial begin
      {enable, conv_irq_en, bound_irq_en} = 3'b111;
      {power_down, start_write, timer0_overflow, external_trigger_pin} = 4'h0;
      {irq_group8, scan_irq_after4, bound_inside_sel, done_clear, bound_clear} = 5'h00;
      mode = SAS_MODE_FIXED_SINGLE;
      start_src = SAS_SRC_IMM;
      {chan_sel, dual_ch_a, dual_ch_b} = {3'h0, 3'h1, 3'h6};
      chan_set = 8'h00;
      clk_div = 3'h0;
      bound_low = 10'h100;
      bound_high = 10'h2FF;
      for (int i = 0; i < 8; i++) ana[i] = 10'h05A + 10'(10'h071 * i);
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      check({2'h0, boundary_status}, 10'h000);
      t_single();
      t_cont();
      t_dual();
      t_scan();
      t_starts();
      t_bound();
      report_and_stop();
   end
endmodule
`default_nettype wire
